// File: logic/modem_format_sync_config.sv
// Modem format, sync qualifier and channel spacing exponent registers
//
// How it works
// - Format bit 7 set bypasses the DC blocking filter; clear keeps it.
// - Bits 6:4 pick modulation: 0 2-FSK, 1 GFSK, 3 OOK, 4 4-FSK.
// - Bit 3 enables Manchester; host avoids it in async or 4-FSK use.
// - Qualifier 0 or 4: no sync search; 4 also needs carrier sense.
// - Qualifier 1 or 5: 16-bit sync word, 15 of 16 bits must match.
// - Qualifier 2 or 6: all 16 bits must match; 2 is reset value.
// - Qualifier 3 or 7: 32-bit sync word, 30 of 32 bits must match.
// - Qualifiers 5, 6, 7 additionally require carrier sense.
// - Spacing register bits 1:0 hold the exponent, reset to binary 10.
// - Spacing is crystal over 2^18 times (256 plus mantissa) times 2^E.
`timescale 1ns/1ps
`default_nettype none
`include "mfsc_defs.svh"
module modem_format_sync_config
   import mfsc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Serial register port
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   output logic             spi_miso_oe,
   // Demodulator side
   input  wire logic        rx_bit,
   input  wire logic        rx_bit_valid,
   input  wire logic        carrier_sense,
   input  wire logic [31:0] sync_word,
   input  wire logic [7:0]  spacing_mantissa,
   // Configuration outputs
   output logic             dc_block_bypass,
   output logic [2:0]       modulation_select,
   output logic             manchester_en,
   output logic [2:0]       sync_mode,
   output logic [1:0]       spacing_exponent,
   output logic [11:0]      spacing_factor,
   output logic             sync_found
);
   mfsc_reg_if regs ();

   logic [7:0]  fmt_ff, nxt_fmt;
   logic [7:0]  spc_ff, nxt_spc;
   logic [11:0] factor_ff, nxt_factor;
   logic [31:0] win_ff, nxt_win;
   logic [5:0]  seen_ff, nxt_seen;
   logic        found_ff, nxt_found;
   logic [31:0] win_new;
   logic [5:0]  err16, err32;
   logic        match;

   mfsc_spi_slave mfsc_spi_slave_inst (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .spi_sclk    (spi_sclk),
      .spi_cs_n    (spi_cs_n),
      .spi_mosi    (spi_mosi),
      .spi_miso    (spi_miso),
      .spi_miso_oe (spi_miso_oe),
      .regs        (regs.slave)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register bank

   function automatic logic [7:0] reg_read(
      input logic [`MFSC_ADDR_W-1:0] a,
      input logic [7:0]              f,
      input logic [7:0]              s);
      logic [7:0] r;
      r = 8'h00;
      if (a == `MFSC_ADDR_FMT) begin
         r = f;
      end else if (a == `MFSC_ADDR_SPC) begin
         r = s & `MFSC_SPC_WMASK;
      end
      return r;
   endfunction

   always_comb begin
      nxt_fmt = fmt_ff;
      nxt_spc = spc_ff;
      if (regs.wr_stb && regs.addr == `MFSC_ADDR_FMT) begin
         nxt_fmt = regs.wdata;
      end
      if (regs.wr_stb && regs.addr == `MFSC_ADDR_SPC) begin
         nxt_spc = regs.wdata & `MFSC_SPC_WMASK;
      end
      // Spacing multiplier; crystal scaling is left to the synthesizer
      nxt_factor = (`MFSC_SPC_BASE + {4'h0, spacing_mantissa})
                   << spc_ff[`MFSC_EXP_HI:`MFSC_EXP_LO];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fmt_ff    <= `MFSC_FMT_RESET;
         spc_ff    <= `MFSC_SPC_RESET;
         factor_ff <= 12'h000;
      end else begin
         fmt_ff    <= nxt_fmt;
         spc_ff    <= nxt_spc;
         factor_ff <= nxt_factor;
      end
   end

   assign regs.rdata = reg_read(regs.addr, fmt_ff, spc_ff);

   assign dc_block_bypass   = fmt_ff[`MFSC_DCBYP_BIT];
   assign modulation_select = fmt_ff[`MFSC_MOD_HI:`MFSC_MOD_LO];
   assign manchester_en     = fmt_ff[`MFSC_MAN_BIT];
   assign sync_mode         = fmt_ff[`MFSC_SYNC_HI:`MFSC_SYNC_LO];
   assign spacing_exponent  = spc_ff[`MFSC_EXP_HI:`MFSC_EXP_LO];
   assign spacing_factor    = factor_ff;

   ////////////////////////////////////////////////////////////////////////
   // Sync word qualifier

   function automatic logic [5:0] popcnt(input logic [31:0] v);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < 32; i++) begin
         n = n + {5'h00, v[i]};
      end
      return n;
   endfunction

   assign win_new = {win_ff[30:0], rx_bit};
   assign err16   = popcnt({16'h0000, win_new[15:0] ^ sync_word[15:0]});
   assign err32   = popcnt(win_new ^ sync_word);

   always_comb begin
      unique case (sync_mode[1:0])
         `MFSC_SYNC_OFF:   match = 1'b0;
         `MFSC_SYNC_15_16: match = seen_ff >= `MFSC_LEN_16 - 6'h01
                                   && err16 <= `MFSC_ERR_16;
         `MFSC_SYNC_16_16: match = seen_ff >= `MFSC_LEN_16 - 6'h01
                                   && err16 == 6'h00;
         `MFSC_SYNC_30_32: match = seen_ff >= `MFSC_LEN_32 - 6'h01
                                   && err32 <= `MFSC_ERR_32;
      endcase
   end

   always_comb begin
      nxt_win   = win_ff;
      nxt_seen  = seen_ff;
      nxt_found = 1'b0;
      if (rx_bit_valid) begin
         nxt_win = win_new;
         // Saturate so a long idle stream cannot wrap into a false fill
         if (seen_ff < `MFSC_LEN_32) begin
            nxt_seen = seen_ff + 6'h01;
         end
         nxt_found = match
                     && (!sync_mode[`MFSC_CS_BIT] || carrier_sense);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         win_ff   <= 32'h00000000;
         seen_ff  <= 6'h00;
         found_ff <= 1'b0;
      end else begin
         win_ff   <= nxt_win;
         seen_ff  <= nxt_seen;
         found_ff <= nxt_found;
      end
   end

   assign sync_found = found_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_fmt_write;
      regs.wr_stb && regs.addr == `MFSC_ADDR_FMT;
   endsequence

   property p_dcbyp;
      @(posedge clk) disable iff (sys_rst)
      s_fmt_write |=> dc_block_bypass == $past(regs.wdata[7]);
   endproperty
   a_dcbyp: assert property (p_dcbyp)
      else $error("filter bypass not taken from write");

   property p_modsel;
      @(posedge clk) disable iff (sys_rst)
      s_fmt_write |=> modulation_select == $past(regs.wdata[6:4]);
   endproperty
   a_modsel: assert property (p_modsel)
      else $error("modulation select not written");

   property p_manch;
      @(posedge clk) disable iff (sys_rst)
      s_fmt_write |=> manchester_en == $past(regs.wdata[3]);
   endproperty
   a_manch: assert property (p_manch)
      else $error("manchester enable not written");

   property p_reset_vals;
      @(posedge clk) $past(sys_rst) |->
         sync_mode == 3'h2 && spacing_exponent == 2'h2
         && modulation_select == 3'h0;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("wrong reset values");

   property p_no_sync;
      @(posedge clk) disable iff (sys_rst)
      sync_mode[1:0] == 2'h0 |=> !sync_found;
   endproperty
   a_no_sync: assert property (p_no_sync)
      else $error("sync found with detection off");

   property p_cs_needed;
      @(posedge clk) disable iff (sys_rst)
      sync_mode[2] && !carrier_sense |=> !sync_found;
   endproperty
   a_cs_needed: assert property (p_cs_needed)
      else $error("sync found without carrier sense");

   property p_exact16;
      @(posedge clk) disable iff (sys_rst)
      rx_bit_valid && sync_mode[1:0] == 2'h2 && err16 != 6'h00
      |=> !sync_found;
   endproperty
   a_exact16: assert property (p_exact16)
      else $error("inexact 16-bit word accepted");

   property p_tol16;
      @(posedge clk) disable iff (sys_rst)
      rx_bit_valid && sync_mode == 3'h1 && seen_ff >= 6'h0F
      && err16 <= 6'h01 |=> sync_found;
   endproperty
   a_tol16: assert property (p_tol16)
      else $error("15 of 16 match not accepted");

   property p_tol32;
      @(posedge clk) disable iff (sys_rst)
      rx_bit_valid && sync_mode[1:0] == 2'h3 && err32 > 6'h02
      |=> !sync_found;
   endproperty
   a_tol32: assert property (p_tol32)
      else $error("32-bit word with too many errors");

   property p_spc_zero;
      @(posedge clk) disable iff (sys_rst)
      spc_ff[6:2] == 5'h00;
   endproperty
   a_spc_zero: assert property (p_spc_zero)
      else $error("unused spacing bits set");

   property p_factor;
      @(posedge clk) disable iff (sys_rst)
      $stable(spacing_mantissa) && $stable(spacing_exponent) |=>
         spacing_factor == ((12'h100 + {4'h0, $past(spacing_mantissa)})
                            << $past(spacing_exponent));
   endproperty
   a_factor: assert property (p_factor)
      else $error("spacing factor wrong");
endmodule
`default_nettype wire

// File: logic/mfsc_defs.svh
// Register addresses, field positions, reset values and widths
`ifndef MFSC_DEFS_SVH
`define MFSC_DEFS_SVH

`define MFSC_ADDR_W        6
`define MFSC_ADDR_FMT      6'h12
`define MFSC_ADDR_SPC      6'h13

`define MFSC_FMT_RESET     8'h02
`define MFSC_SPC_RESET     8'h02
`define MFSC_SPC_WMASK     8'h83

`define MFSC_DCBYP_BIT     7
`define MFSC_MOD_HI        6
`define MFSC_MOD_LO        4
`define MFSC_MAN_BIT       3
`define MFSC_SYNC_HI       2
`define MFSC_SYNC_LO       0
`define MFSC_EXP_HI        1
`define MFSC_EXP_LO        0
`define MFSC_CS_BIT        2

`define MFSC_SYNC_OFF      2'h0
`define MFSC_SYNC_15_16    2'h1
`define MFSC_SYNC_16_16    2'h2
`define MFSC_SYNC_30_32    2'h3
`define MFSC_ERR_16        6'h01
`define MFSC_ERR_32        6'h02
`define MFSC_LEN_16        6'h10
`define MFSC_LEN_32        6'h20

`define MFSC_SPC_BASE      12'h100
`define MFSC_RNW_BIT       7
`define MFSC_LAST_BIT      3'h7
// Pin idle levels as {select, clock, data}: deselected, clock low
`define MFSC_PIN_IDLE      3'h4

`endif

// File: logic/mfsc_pkg.sv
// Shared types of the modem format and sync configuration block
`default_nettype none
package mfsc_pkg;
   typedef enum logic {MFSC_SPI_HDR, MFSC_SPI_DATA} mfsc_spi_state_type;
endpackage
`default_nettype wire

// File: logic/mfsc_reg_if.sv
// Register access carrier between serial slave and register bank
`timescale 1ns/1ps
`default_nettype none
`include "mfsc_defs.svh"
interface mfsc_reg_if;
   logic                      wr_stb;
   logic [`MFSC_ADDR_W-1:0]   addr;
   logic [7:0]                wdata;
   logic [7:0]                rdata;
   modport slave (output wr_stb, output addr, output wdata, input rdata);
   modport bank  (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: logic/mfsc_spi_slave.sv
// Serial peripheral slave: header byte then one data byte, mode 0
`timescale 1ns/1ps
`default_nettype none
`include "mfsc_defs.svh"
module mfsc_spi_slave
   import mfsc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Serial pins
   input  wire logic spi_sclk,
   input  wire logic spi_cs_n,
   input  wire logic spi_mosi,
   output logic      spi_miso,
   output logic      spi_miso_oe,
   // Register access
   mfsc_reg_if.slave regs
);
   logic [2:0]              sclk_s1_ff, sclk_s2_ff;
   logic                    sclk_d_ff;
   mfsc_spi_state_type      state_ff, nxt_state;
   logic [2:0]              cnt_ff, nxt_cnt;
   logic [7:0]              sh_ff, nxt_sh;
   logic                    rnw_ff, nxt_rnw;
   logic [`MFSC_ADDR_W-1:0] addr_ff, nxt_addr;
   logic [7:0]              wdata_ff, nxt_wdata;
   logic                    wr_ff, nxt_wr;
   logic                    miso_ff, nxt_miso;
   logic                    oe_ff, nxt_oe;
   logic                    rise, fall, cs_n, mosi;
   logic [7:0]              byte_in;

   // Pins from outside pass two flops before use
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // Idle levels, else reset fakes a select and raises the enable
         sclk_s1_ff <= `MFSC_PIN_IDLE;
         sclk_s2_ff <= `MFSC_PIN_IDLE;
         sclk_d_ff  <= 1'b0;
      end else begin
         sclk_s1_ff <= {spi_cs_n, spi_sclk, spi_mosi};
         sclk_s2_ff <= sclk_s1_ff;
         sclk_d_ff  <= sclk_s2_ff[1];
      end
   end

   assign cs_n    = sclk_s2_ff[2];
   assign mosi    = sclk_s2_ff[0];
   assign rise    = sclk_s2_ff[1] & ~sclk_d_ff;
   assign fall    = ~sclk_s2_ff[1] & sclk_d_ff;
   assign byte_in = {sh_ff[6:0], mosi};

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_sh    = sh_ff;
      nxt_rnw   = rnw_ff;
      nxt_addr  = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_wr    = 1'b0;
      nxt_miso  = miso_ff;
      nxt_oe    = ~cs_n;
      if (cs_n) begin
         nxt_state = MFSC_SPI_HDR;
         nxt_cnt   = 3'h0;
         nxt_miso  = 1'b0;
      end else if (rise) begin
         nxt_sh  = byte_in;
         nxt_cnt = cnt_ff + 3'h1;
         if (cnt_ff == `MFSC_LAST_BIT) begin
            unique case (state_ff)
               MFSC_SPI_HDR: begin
                  nxt_rnw   = byte_in[`MFSC_RNW_BIT];
                  nxt_addr  = byte_in[`MFSC_ADDR_W-1:0];
                  nxt_state = MFSC_SPI_DATA;
               end
               MFSC_SPI_DATA: begin
                  nxt_wdata = byte_in;
                  nxt_wr    = ~rnw_ff;
                  nxt_state = MFSC_SPI_HDR;
               end
            endcase
         end
      end else if (fall) begin
         // Read data leads each rising edge by half a bit
         if (state_ff == MFSC_SPI_DATA && rnw_ff) begin
            nxt_miso = regs.rdata[`MFSC_LAST_BIT - cnt_ff];
         end else begin
            nxt_miso = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= MFSC_SPI_HDR;
         cnt_ff   <= 3'h0;
         sh_ff    <= 8'h00;
         rnw_ff   <= 1'b0;
         addr_ff  <= '0;
         wdata_ff <= 8'h00;
         wr_ff    <= 1'b0;
         miso_ff  <= 1'b0;
         oe_ff    <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         sh_ff    <= nxt_sh;
         rnw_ff   <= nxt_rnw;
         addr_ff  <= nxt_addr;
         wdata_ff <= nxt_wdata;
         wr_ff    <= nxt_wr;
         miso_ff  <= nxt_miso;
         oe_ff    <= nxt_oe;
      end
   end

   assign regs.wr_stb = wr_ff;
   assign regs.addr   = addr_ff;
   assign regs.wdata  = wdata_ff;
   assign spi_miso    = miso_ff;
   assign spi_miso_oe = oe_ff;
endmodule
`default_nettype wire

// File: test/mfsc_host_model.sv
// Host-side serial master model driving the register port
`timescale 1ns/1ps
`default_nettype none
module mfsc_host_model (
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe
);
   // Half period of 8 clk keeps sclk well under the 12.5 MHz ceiling
   localparam int HALF = 8;

   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Header byte then data byte, mode 0, MSB first; sclk idles low
   task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge clk);
      #1;
      spi_cs_n = 1'b0;
      spi_mosi = frame[15];
      for (int i = 15; i >= 0; i--) begin
         repeat (HALF) @(posedge clk);
         // Undriven line reads unknown so a missing enable shows up
         if (i < 8) begin
            rd[i] = spi_miso_oe ? spi_miso : 1'bx;
         end
         #1;
         spi_sclk = 1'b1;
         repeat (HALF) @(posedge clk);
         #1;
         spi_sclk = 1'b0;
         if (i > 0) begin
            spi_mosi = frame[i-1];
         end
      end
      repeat (HALF) @(posedge clk);
      #1;
      spi_cs_n = 1'b1;
      // Released data line must not keep looking valid
      spi_mosi = ~spi_mosi;
      repeat (HALF) @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// File: test/modem_format_sync_config_test.sv
// Self-checking bench for the modem format and sync configuration block
`timescale 1ns/1ps
`default_nettype none
`include "mfsc_defs.svh"
module modem_format_sync_config_test;
   logic        clk, sys_rst, spi_sclk, spi_cs_n, spi_mosi;
   logic        spi_miso, spi_miso_oe, rx_bit, rx_bit_valid;
   logic        carrier_sense, dc_block_bypass, manchester_en, sync_found;
   logic [31:0] sync_word;
   logic [7:0]  spacing_mantissa;
   logic [2:0]  modulation_select;
   logic [2:0]  sync_mode;
   logic [1:0]  spacing_exponent;
   logic [11:0] spacing_factor;
   int          failures;
   int          total_checks;

   localparam logic [31:0] SYNC = 32'h5A3C_6C2B;

   modem_format_sync_config modem_format_sync_config_inst (
      .clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid), .carrier_sense(carrier_sense),
      .sync_word(sync_word), .spacing_mantissa(spacing_mantissa),
      .dc_block_bypass(dc_block_bypass),
      .modulation_select(modulation_select),
      .manchester_en(manchester_en), .sync_mode(sync_mode),
      .spacing_exponent(spacing_exponent),
      .spacing_factor(spacing_factor), .sync_found(sync_found)
   );

   mfsc_host_model mfsc_host_model_inst (
      .clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe)
   );

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk_val(string name, logic [11:0] exp, logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_bit(string name, logic exp, logic got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic reg_wr(logic [5:0] a, logic [7:0] d);
      logic [7:0] unused;
      mfsc_host_model_inst.xfer({2'b00, a, d}, unused);
   endtask

   task automatic reg_rd(logic [5:0] a, output logic [7:0] d);
      mfsc_host_model_inst.xfer({2'b10, a, 8'h00}, d);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [7:0] d;
      reg_rd(`MFSC_ADDR_FMT, d);
      chk_val("format reg", 12'h002, 12'(d));
      chk_bit("dc bypass", 1'b0, dc_block_bypass);
      chk_val("sync mode", 12'h002, 12'(sync_mode));
      reg_rd(`MFSC_ADDR_SPC, d);
      chk_val("spacing reg", 12'h002, 12'(d));
      chk_val("exponent", 12'h002, 12'(spacing_exponent));
   endtask

   task automatic t_format;
      logic [7:0] d;
      logic [7:0] w;
      for (int m = 0; m < 8; m++) begin
         // Bypass assumes a slow data rate; no Manchester with 4-FSK
         w = {m[0], m[2:0], (m != 4) & m[1], m[2:0]};
         reg_wr(`MFSC_ADDR_FMT, w);
         reg_rd(`MFSC_ADDR_FMT, d);
         chk_val("format reg", 12'(w), 12'(d));
         chk_bit("dc bypass", w[7], dc_block_bypass);
         chk_val("modulation", 12'(w[6:4]), 12'(modulation_select));
         chk_bit("manchester", w[3], manchester_en);
         chk_val("sync mode", 12'(w[2:0]), 12'(sync_mode));
      end
   endtask

   task automatic t_unmapped;
      logic [7:0] d;
      reg_wr(6'h20, 8'hA5);
      reg_rd(6'h20, d);
      chk_val("unmapped", 12'h000, 12'(d));
      reg_rd(`MFSC_ADDR_FMT, d);
      chk_val("format kept", 12'h0FF, 12'(d));
   endtask

   task automatic t_spacing;
      logic [7:0] d;
      logic [1:0] e;
      for (int i = 0; i < 4; i++) begin
         e = 2'(i);
         spacing_mantissa = {e, e, e, e};
         reg_wr(`MFSC_ADDR_SPC, {e[0], 5'h1F, e});
         reg_rd(`MFSC_ADDR_SPC, d);
         chk_val("spacing reg", 12'({e[0], 5'h00, e}), 12'(d));
         chk_val("exponent", 12'(e), 12'(spacing_exponent));
         chk_val("factor", (12'h100 + 12'(spacing_mantissa)) << e,
                 spacing_factor);
      end
   endtask

   // Reset after every field was written must restore all of them
   task automatic t_midreset;
      logic [7:0] d;
      sys_rst = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk_bit("miso enable", 1'b0, spi_miso_oe);
      chk_bit("dc bypass", 1'b0, dc_block_bypass);
      chk_val("modulation", 12'h000, 12'(modulation_select));
      chk_bit("manchester", 1'b0, manchester_en);
      chk_val("sync mode", 12'h002, 12'(sync_mode));
      chk_val("exponent", 12'h002, 12'(spacing_exponent));
      chk_val("factor", (12'h100 + 12'(spacing_mantissa)) << 2,
              spacing_factor);
      reg_rd(`MFSC_ADDR_FMT, d);
      chk_val("format reg", 12'h002, 12'(d));
      reg_rd(`MFSC_ADDR_SPC, d);
      chk_val("spacing reg", 12'h002, 12'(d));
   endtask

   task automatic sync_case(logic [2:0] mode, logic cs, logic [31:0] err,
                            logic exp);
      logic [31:0] bits;
      bits = SYNC ^ err;
      reg_wr(`MFSC_ADDR_FMT, {5'h00, mode});
      carrier_sense = cs;
      for (int i = 31; i >= 0; i--) begin
         rx_bit = bits[i];
         rx_bit_valid = 1'b1;
         @(posedge clk);
         #1;
         rx_bit_valid = 1'b0;
         if (i == 0) begin
            chk_bit("sync found", exp, sync_found);
         end
         @(posedge clk);
         #1;
      end
   endtask

   task automatic t_sync;
      sync_case(3'h0, 1'b1, 32'h0, 1'b0);
      sync_case(3'h4, 1'b1, 32'h0, 1'b0);
      sync_case(3'h1, 1'b0, 32'h0000_0008, 1'b1);
      sync_case(3'h1, 1'b0, 32'h0000_0408, 1'b0);
      sync_case(3'h2, 1'b0, 32'hFFFF_0000, 1'b1);
      sync_case(3'h2, 1'b0, 32'h0000_8000, 1'b0);
      sync_case(3'h3, 1'b0, 32'h8000_0001, 1'b1);
      sync_case(3'h3, 1'b0, 32'h8001_0001, 1'b0);
      sync_case(3'h5, 1'b0, 32'h0000_0008, 1'b0);
      sync_case(3'h5, 1'b1, 32'h0000_0008, 1'b1);
      sync_case(3'h6, 1'b1, 32'h0, 1'b1);
      sync_case(3'h6, 1'b0, 32'h0, 1'b0);
      sync_case(3'h7, 1'b0, 32'h0, 1'b0);
      sync_case(3'h7, 1'b1, 32'h0200_0040, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      $display("mismatch run length expected done seen hung");
      results();
   end

   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      rx_bit = 1'b0;
      rx_bit_valid = 1'b0;
      carrier_sense = 1'b0;
      sync_word = SYNC;
      spacing_mantissa = 8'hF8;
      failures = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      repeat (3) @(posedge clk);
      t_reset();
      t_format();
      t_unmapped();
      t_spacing();
      t_midreset();
      t_sync();
      results();
   end
endmodule
`default_nettype wire
